// ---- occ_output_compare.sv ----
// Output compare channel with its register file on a classic Wishbone slave.
// Assumes both timers and the idle and fault inputs are synchronous to clk_i.
//
// The register offsets and register access over Wishbone are this design's own decisions.
`default_nettype none

module occ_output_compare
  import occ_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [OCC_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [OCC_DAT_W-1:0] wb_dat_i,
  output logic      [OCC_DAT_W-1:0] wb_dat_o,
  output logic                      wb_ack_o,
  input  wire logic [31:0]          second_timer_i,
  input  wire logic [31:0]          third_timer_i,
  input  wire logic                 cpu_idle_i,
  input  wire logic                 fault_n_i,
  output logic                      compare_output_pin_o
);

  occ_ctrl_t   ctrl_reg;
  occ_ctrl_t   ctrl_next;
  logic [31:0] pri_reg;
  logic [31:0] pri_next;
  logic [31:0] sec_reg;
  logic [31:0] sec_next;
  logic [31:0] duty_reg;
  logic [31:0] duty_next;
  logic [31:0] rdata_reg;
  logic        ack_reg;
  logic        pin_reg;
  logic        pin_next;
  logic        flt_reg;
  logic        flt_next;
  occ_state_t  state_reg;
  occ_state_t  state_next;
  occ_mode_t   mode_last_reg;
  logic        en_last_reg;

  logic        bus_req;
  logic        bus_wr;
  logic        hit_ctrl;
  logic        hit_pri;
  logic        hit_sec;
  logic [31:0] ctrl_word;
  logic [31:0] ctrl_wmerge;
  logic [31:0] rdata_next;
  logic [31:0] timer_val;
  logic        run;
  logic        reinit;
  logic        fault_active;
  logic        pri_evt;
  logic        sec_evt;
  logic        duty_evt;
  logic        per_evt;
  logic        fault_mode;
  logic        idle_halt;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  // Bus decode. One wait state: ack rises the cycle after the request and drops after one cycle.
  assign bus_req  = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign bus_wr   = bus_req & wb_we_i;
  assign hit_ctrl = (wb_adr_i == OCC_CTRL_OFS);
  assign hit_pri  = (wb_adr_i == OCC_PRI_OFS);
  assign hit_sec  = (wb_adr_i == OCC_SEC_OFS);

  // Only implemented fields are placed; every other bit stays zero.
  always_comb begin
    ctrl_word                                          = OCC_READ_ZERO;
    ctrl_word[OCC_EN_BIT]                              = ctrl_reg.enable;
    ctrl_word[OCC_IDLE_BIT]                            = ctrl_reg.idle_stop;
    ctrl_word[OCC_WIDE_BIT]                            = ctrl_reg.wide_compare;
    ctrl_word[OCC_FLT_BIT]                             = flt_reg &
        fault_mode;
    ctrl_word[OCC_TSEL_BIT]                            = ctrl_reg.timer_select;
    ctrl_word[OCC_MODE_LSB +: OCC_MODE_W]              = ctrl_reg.mode_field;
  end

  assign ctrl_wmerge = merge_bytes(ctrl_word, wb_dat_i, wb_sel_i);

  // The fault bit in the written word is dropped here, so software cannot touch the flag.
  always_comb begin
    ctrl_next = ctrl_reg;
    if (bus_wr && hit_ctrl) begin
      ctrl_next.enable       = ctrl_wmerge[OCC_EN_BIT];
      ctrl_next.idle_stop    = ctrl_wmerge[OCC_IDLE_BIT];
      ctrl_next.wide_compare = ctrl_wmerge[OCC_WIDE_BIT];
      ctrl_next.timer_select = ctrl_wmerge[OCC_TSEL_BIT];
      ctrl_next.mode_field   = occ_mode_t'(ctrl_wmerge[OCC_MODE_LSB +: OCC_MODE_W]);
    end
  end

  assign pri_next = (bus_wr && hit_pri) ? merge_bytes(pri_reg, wb_dat_i, wb_sel_i) : pri_reg;
  assign sec_next = (bus_wr && hit_sec) ? merge_bytes(sec_reg, wb_dat_i, wb_sel_i) : sec_reg;

  // Unmapped addresses are acknowledged and read as zero.
  assign rdata_next = hit_ctrl ? ctrl_word :
                      hit_pri  ? pri_reg   :
                      hit_sec  ? sec_reg   : OCC_READ_ZERO;

  // Time base and run gating.
  // Idle stop only freezes the pin logic; the pin and the control fields keep their values, but a fault still sets the fault flag.
  assign idle_halt  = ctrl_reg.idle_stop & cpu_idle_i;
  assign fault_mode = (ctrl_reg.mode_field == OCC_MODE_PWM_FAULT);
  assign timer_val = ctrl_reg.timer_select ? third_timer_i : second_timer_i;
  assign run       = ctrl_reg.enable
                   & ~idle_halt
                   & (ctrl_reg.mode_field != OCC_MODE_OFF);
  assign reinit    = (ctrl_reg.mode_field != mode_last_reg) | (ctrl_reg.enable & ~en_last_reg);
  assign fault_active = ctrl_reg.enable & ~fault_n_i &
                        fault_mode;

  // Width of every comparison follows the wide-compare bit.
  occ_match u_pri_match (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .enable_i  (run),
    .wide_i    (ctrl_reg.wide_compare),
    .timer_i   (timer_val),
    .compare_i (pri_reg),
    .event_o   (pri_evt)
  );

  occ_match u_sec_match (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .enable_i  (run),
    .wide_i    (ctrl_reg.wide_compare),
    .timer_i   (timer_val),
    .compare_i (sec_reg),
    .event_o   (sec_evt)
  );

  // PWM uses a latched duty value so a new secondary takes effect only at a period start, a mode change or the enable rising.
  occ_match u_duty_match (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .enable_i  (run),
    .wide_i    (ctrl_reg.wide_compare),
    .timer_i   (timer_val),
    .compare_i (duty_reg),
    .event_o   (duty_evt)
  );

  occ_match u_period_match (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .enable_i  (run),
    .wide_i    (ctrl_reg.wide_compare),
    .timer_i   (timer_val),
    .compare_i (OCC_PERIOD_VAL),
    .event_o   (per_evt)
  );

  // Pin behaviour per mode.
  // In fault PWM mode a fault outranks both PWM events, so while the channel runs the pin stays low for as long as fault_n_i is low.
  always_comb begin
    pin_next   = pin_reg;
    state_next = state_reg;
    duty_next  = duty_reg;
    if (!ctrl_reg.enable) begin
      pin_next   = 1'b0;
      state_next = OCC_ST_WAIT_RISE;
    end else if (reinit) begin
      pin_next   = (ctrl_reg.mode_field == OCC_MODE_SET_LOW);
      state_next = OCC_ST_WAIT_RISE;
      duty_next  = sec_reg;
    end else if (run) begin
      case (ctrl_reg.mode_field)
        OCC_MODE_SET_HIGH: begin
          if (pri_evt) pin_next = 1'b1;
        end
        OCC_MODE_SET_LOW: begin
          if (pri_evt) pin_next = 1'b0;
        end
        OCC_MODE_TOGGLE: begin
          if (pri_evt) pin_next = ~pin_reg;
        end
        OCC_MODE_PULSE_ONE, OCC_MODE_PULSE_RUN: begin
          case (state_reg)
            OCC_ST_WAIT_RISE: begin
              if (pri_evt) begin
                pin_next   = 1'b1;
                state_next = OCC_ST_WAIT_FALL;
              end
            end
            OCC_ST_WAIT_FALL: begin
              if (sec_evt) begin
                pin_next   = 1'b0;
                state_next = (ctrl_reg.mode_field == OCC_MODE_PULSE_RUN) ?
                             OCC_ST_WAIT_RISE : OCC_ST_DONE;
              end
            end
            OCC_ST_DONE: begin
              pin_next = 1'b0;
            end
            default: begin
              state_next = OCC_ST_WAIT_RISE;
            end
          endcase
        end
        OCC_MODE_PWM, OCC_MODE_PWM_FAULT: begin
          if (fault_active) begin
            pin_next = 1'b0;
          end else begin
            if (per_evt) begin
              pin_next  = 1'b1;
              duty_next = sec_reg;
            end
            if (duty_evt) pin_next = 1'b0;
          end
        end
        default: begin
          pin_next = 1'b0;
        end
      endcase
    end
  end

  // A fault in the clearing cycle keeps the flag set; it clears at a fault-free period start or whenever the mode is not fault PWM.
  assign flt_next = fault_active ? 1'b1 :
                    !fault_mode ? 1'b0 :
                    (per_evt & fault_n_i) ? 1'b0 : flt_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg  <= OCC_CTRL_RESET;
      pri_reg   <= OCC_CMP_RESET;
      sec_reg   <= OCC_CMP_RESET;
      ack_reg   <= 1'b0;
      rdata_reg <= OCC_READ_ZERO;
    end else begin
      ctrl_reg  <= ctrl_next;
      pri_reg   <= pri_next;
      sec_reg   <= sec_next;
      ack_reg   <= bus_req;
      rdata_reg <= bus_req ? rdata_next : OCC_READ_ZERO;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_reg       <= 1'b0;
      flt_reg       <= 1'b0;
      duty_reg      <= OCC_CMP_RESET;
      state_reg     <= OCC_ST_WAIT_RISE;
      mode_last_reg <= OCC_MODE_OFF;
      en_last_reg   <= 1'b0;
    end else begin
      pin_reg       <= pin_next;
      flt_reg       <= flt_next;
      duty_reg      <= duty_next;
      state_reg     <= state_next;
      mode_last_reg <= ctrl_reg.mode_field;
      en_last_reg   <= ctrl_reg.enable;
    end
  end

  assign wb_ack_o             = ack_reg;
  assign wb_dat_o             = rdata_reg;
  assign compare_output_pin_o = pin_reg;

endmodule : occ_output_compare

`default_nettype wire

// ---- occ_pkg.sv ----
// Shared constants and types of the output compare channel.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
`default_nettype none

package occ_pkg;

  localparam int unsigned OCC_ADR_W = 4;
  localparam int unsigned OCC_DAT_W = 32;

  localparam logic [3:0] OCC_CTRL_OFS = 4'h0;
  localparam logic [3:0] OCC_PRI_OFS  = 4'h4;
  localparam logic [3:0] OCC_SEC_OFS  = 4'h8;

  localparam int unsigned OCC_EN_BIT    = 15;
  localparam int unsigned OCC_IDLE_BIT  = 13;
  localparam int unsigned OCC_WIDE_BIT  = 5;
  localparam int unsigned OCC_FLT_BIT   = 4;
  localparam int unsigned OCC_TSEL_BIT  = 3;
  localparam int unsigned OCC_MODE_LSB  = 0;
  localparam int unsigned OCC_MODE_W    = 3;

  localparam logic [31:0] OCC_CMP_RESET  = 32'h0000_0000;
  localparam logic [31:0] OCC_READ_ZERO  = 32'h0000_0000;
  localparam logic [31:0] OCC_PERIOD_VAL = 32'h0000_0000;

  typedef enum logic [2:0] {
    OCC_MODE_OFF       = 3'h0,
    OCC_MODE_SET_HIGH  = 3'h1,
    OCC_MODE_SET_LOW   = 3'h2,
    OCC_MODE_TOGGLE    = 3'h3,
    OCC_MODE_PULSE_ONE = 3'h4,
    OCC_MODE_PULSE_RUN = 3'h5,
    OCC_MODE_PWM       = 3'h6,
    OCC_MODE_PWM_FAULT = 3'h7
  } occ_mode_t;

  typedef enum logic [2:0] {
    OCC_ST_WAIT_RISE = 3'b001,
    OCC_ST_WAIT_FALL = 3'b010,
    OCC_ST_DONE      = 3'b100
  } occ_state_t;

  typedef struct packed {
    logic      enable;
    logic      idle_stop;
    logic      wide_compare;
    logic      timer_select;
    occ_mode_t mode_field;
  } occ_ctrl_t;

  localparam occ_ctrl_t OCC_CTRL_RESET = '{
    enable:       1'b0,
    idle_stop:    1'b0,
    wide_compare: 1'b0,
    timer_select: 1'b0,
    mode_field:   OCC_MODE_OFF
  };

endpackage : occ_pkg

`default_nettype wire

// ---- occ_match.sv ----
// Equality detector between a timer value and a compare value.
// Assumes the timer is synchronous to clk_i and may hold a value for many cycles.
`default_nettype none

module occ_match
  import occ_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        enable_i,
  input  wire logic        wide_i,
  input  wire logic [31:0] timer_i,
  input  wire logic [31:0] compare_i,
  output logic             event_o
);

  logic match;
  logic match_prev_reg;
  logic event_reg;

  // A slow timer keeps its value for many cycles, so only the first equal cycle counts.
  assign match = wide_i ? (timer_i == compare_i)
                        : (timer_i[15:0] == compare_i[15:0]);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      match_prev_reg <= 1'b0;
      event_reg      <= 1'b0;
    end else begin
      match_prev_reg <= match;
      event_reg      <= enable_i & match & ~match_prev_reg;
    end
  end

  assign event_o = event_reg;

endmodule : occ_match

`default_nettype wire

// ---- occ_load.sv ----
// Model of the load on the compare output: it counts rising edges of the pin.
// Assumes the pin is sampled on the channel clock, so pulses under one cycle go unseen.
`default_nettype none
module occ_load (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       pin_i,
  output logic      [7:0] rise_cnt_o
);
  logic pin_reg;
  always_ff @(posedge clk_i) begin
    pin_reg <= pin_i;
    if (rst_i) rise_cnt_o <= 8'h00;
    else if (pin_i && !pin_reg) rise_cnt_o <= rise_cnt_o + 8'h01;
  end
endmodule : occ_load
`default_nettype wire

// ---- occ_chk_assertions.sv ----
// Checker of the output compare channel, bound to its top module.
// Assumes control writes use both low byte lanes; a shadow word follows them.
`default_nettype none
module occ_chk
  import occ_pkg::*;
(
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic                 wb_we_i,
  input wire logic [OCC_ADR_W-1:0] wb_adr_i,
  input wire logic [OCC_DAT_W-1:0] wb_dat_i,
  input wire logic [OCC_DAT_W-1:0] wb_dat_o,
  input wire logic                 wb_ack_o,
  input wire logic                 cpu_idle_i,
  input wire logic                 fault_n_i,
  input wire logic                 compare_output_pin_o
);
  logic [15:0] sh_reg;
  wire logic wr_c = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == OCC_CTRL_OFS;
  wire logic rd_c = wb_ack_o && !wb_we_i && wb_adr_i == OCC_CTRL_OFS;
  wire logic en = sh_reg[OCC_EN_BIT];
  wire logic [2:0] md = sh_reg[2:0];
  wire logic pin = compare_output_pin_o;
  always_ff @(posedge clk_i) begin
    if (rst_i) sh_reg <= 16'h0000;
    else if (wr_c) sh_reg <= wb_dat_i[15:0];
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_rsvd_zero: assert property (rd_c |-> (wb_dat_o & 32'hffff_5fc0) == 32'h0000_0000)
    else $error("reserved control bits read nonzero");
  chk_flag_mode: assert property (rd_c && wb_dat_o[2:0] != 3'h7 |-> !wb_dat_o[OCC_FLT_BIT])
    else $error("fault flag set outside fault pwm mode");
  chk_off_low: assert property (!en [*4] |-> !pin)
    else $error("pin high while disabled");
  chk_mode_off: assert property ((en && md == 3'h0) [*4] |-> !pin)
    else $error("pin high in mode zero");
  chk_set_high: assert property ((en && md == 3'h1) [*4] |-> !$fell(pin))
    else $error("pin fell in force high mode");
  chk_set_low: assert property ((en && md == 3'h2) [*4] |-> !$rose(pin))
    else $error("pin rose in force low mode");
  chk_fault_low: assert property ((en && md == 3'h7 && !cpu_idle_i) [*4] ##0 !fault_n_i
    |=> !pin)
    else $error("pin not low on fault");
  chk_idle_hold: assert property ((en && sh_reg[OCC_IDLE_BIT] && cpu_idle_i) [*3]
    |-> $stable(pin))
    else $error("pin moved while halted in idle");
  cover property (en && md == 3'h1 ##1 $rose(pin));
  cover property (rd_c && wb_dat_o[OCC_FLT_BIT]);
  cover property (en && md == 3'h5 && $fell(pin));
endmodule : occ_chk
bind occ_output_compare occ_chk i_occ_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .cpu_idle_i(cpu_idle_i), .fault_n_i(fault_n_i),
  .compare_output_pin_o(compare_output_pin_o)
);
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench of the output compare channel.
// Assumes a classic Wishbone slave; the bench drives both timers and a load counts pulses.
`default_nettype none
module tb_top
  import occ_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] ID = 32'h5555_aaaa, P = 32'h1234_5678, S = 32'h0000_0900;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic fault_n = 1'b1, idle = 1'b0, ack, pin, ts = 1'b0;
  logic [3:0] adr = 4'h0, sel = 4'h0, wsel = 4'hf;
  logic [31:0] wdat = 32'h0000_0000, t2 = ID, t3 = ID, rdat, dat_o, seed = 32'hab23_6489;
  logic [7:0] rises, r0;
  int error_cnt = 0, n_checks = 0, cyc_cnt = 0;
  always #5 clk_i = ~clk_i;
  occ_output_compare i_occ_output_compare (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .second_timer_i(t2), .third_timer_i(t3),
    .cpu_idle_i(idle), .fault_n_i(fault_n), .compare_output_pin_o(pin));
  occ_load i_occ_load (.clk_i(clk_i), .rst_i(rst_i), .pin_i(pin), .rise_cnt_o(rises));
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic pchk(input logic e);
    chk(32'(pin), 32'(e));
  endtask : pchk
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= wsel;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
    @(posedge clk_i);
  endtask : wb
  task automatic setm(input logic [31:0] c);
    wb(1'b1, OCC_CTRL_OFS, c);
    repeat (3) @(posedge clk_i);
  endtask : setm
  task automatic hit(input logic [31:0] v2, input logic [31:0] v3);
    t2 <= v2;
    t3 <= v3;
    @(posedge clk_i);
    t2 <= ID;
    t3 <= ID;
    repeat (4) @(posedge clk_i);
  endtask : hit
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs
  function automatic logic [31:0] ctrl_exp(input logic [31:0] w);
    return w & 32'h0000_a02f;
  endfunction : ctrl_exp
  initial begin
    logic b;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int a = 0; a < 16; a += 4) begin
      wb(1'b0, 4'(a), 32'h0000_0000);
      chk(rdat, 32'h0000_0000);
    end
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      wb(1'b1, OCC_SEC_OFS, seed);
      wb(1'b0, OCC_SEC_OFS, 32'h0000_0000);
      chk(rdat, seed);
      seed = xs(seed);
      wb(1'b1, OCC_CTRL_OFS, seed);
      wb(1'b0, OCC_CTRL_OFS, 32'h0000_0000);
      chk(rdat, ctrl_exp(seed));
    end
    wb(1'b1, OCC_SEC_OFS, S);
    wb(1'b1, OCC_PRI_OFS, P);
    wsel = 4'h5;
    wb(1'b1, OCC_PRI_OFS, 32'h0000_0000);
    wsel = 4'hf;
    wb(1'b0, OCC_PRI_OFS, 32'h0000_0000);
    chk(rdat, P & 32'hff00_ff00);
    wb(1'b1, OCC_PRI_OFS, P);
    for (int k = 0; k < 4; k++) begin
      ts = k[0];
      setm(32'h0000_0001);
      setm(32'h0000_8001 | (32'(k[0]) << 3) | (32'(k[1]) << 5));
      pchk(1'b0);
      hit(ts ? P : ID, ts ? ID : P);
      pchk(1'b0);
      hit(ts ? ID : P ^ 32'hffff_0000, ts ? P ^ 32'hffff_0000 : ID);
      pchk(!k[1]);
      hit(ts ? ID : P, ts ? P : ID);
      pchk(1'b1);
    end
    setm(32'h0000_8002);
    pchk(1'b1);
    hit(P, ID);
    pchk(1'b0);
    setm(32'h0000_a003);
    b = pin;
    hit(P, ID);
    pchk(!b);
    idle <= 1'b1;
    hit(P, ID);
    pchk(!b);
    wb(1'b1, OCC_CTRL_OFS, 32'h0000_8003);
    hit(P, ID);
    pchk(b);
    idle <= 1'b0;
    setm(32'h0000_8004);
    pchk(1'b0);
    hit(P, ID);
    pchk(1'b1);
    hit(S, ID);
    pchk(1'b0);
    r0 = rises;
    hit(P, ID);
    hit(S, ID);
    chk(32'(rises), 32'(r0));
    setm(32'h0000_8005);
    r0 = rises;
    repeat (2) begin
      hit(P, ID);
      hit(S, ID);
    end
    chk(32'(rises), 32'(r0 + 8'h02));
    setm(32'h0000_8006);
    fault_n <= 1'b0;
    hit(32'h0000_0000, ID);
    pchk(1'b1);
    wb(1'b0, OCC_CTRL_OFS, 32'h0000_0000);
    chk(rdat, 32'h0000_8006);
    hit(S, ID);
    pchk(1'b0);
    fault_n <= 1'b1;
    setm(32'h0000_8007);
    hit(32'h0000_0000, ID);
    pchk(1'b1);
    fault_n <= 1'b0;
    repeat (2) @(posedge clk_i);
    pchk(1'b0);
    fault_n <= 1'b1;
    wb(1'b0, OCC_CTRL_OFS, 32'h0000_0000);
    chk(rdat, 32'h0000_8017);
    wb(1'b1, OCC_CTRL_OFS, 32'h0000_8007);
    wb(1'b0, OCC_CTRL_OFS, 32'h0000_0000);
    chk(rdat, 32'h0000_8017);
    hit(32'h0000_0000, ID);
    wb(1'b0, OCC_CTRL_OFS, 32'h0000_0000);
    chk(rdat, 32'h0000_8007);
    setm(32'h0000_8000);
    hit(P, ID);
    pchk(1'b0);
    setm(32'h0000_0001);
    hit(P, ID);
    pchk(1'b0);
    setm(32'h0000_8001);
    hit(P, ID);
    pchk(1'b1);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, OCC_CTRL_OFS, 32'h0000_0000);
    chk(rdat, 32'h0000_0000);
    pchk(1'b0);
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
